// ===== logic/uart_serial_receiver.v
// receive half of a serial port with an axi4-lite register slave
//
// How it works
// - enable bit hands rx pin to receiver
// - sync mode samples on transfer clock pin
// - valid start bit, then shift bits in
// - only first stop bit is checked
// - finished frame moves into receive buffer
// - unused upper data bits read zero
// - ninth bit shown in control, kept stored
// - data read advances the receive fifo
// - complete flag means buffer holds data
// - irq follows complete flag when enabled
// - disable stops, flushes, releases the pin
// - error flags stored, read only, no irq
// - frame error means stop sampled low
// - overrun when full, held, new start
// - overrun clears on successful transfer
// - parity checked odd or even per type
// - parity error zero when checking off
// - sixteen or eight samples per bit
// - async start accepted by centre sample majority
// - in async mode each bit decided by three-sample vote
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_regs.vh"

module uart_serial_receiver #(
	parameter ADDR_W = 5
) (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write channels
	input wire [ADDR_W-1:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// axi4-lite read channels
	input wire [ADDR_W-1:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// serial pins
	input wire rxd_pin,
	input wire transfer_clock_pin,
	output reg rx_pin_override,
	// receive complete request
	output reg rx_irq
);

	// receiver states
	localparam ST_IDLE = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_BITS = 2'h2;
	localparam ST_STOP = 2'h3;

	// software controls
	reg rx_enable_bit; // receiver on
	reg rx_complete_irq_enable; // request enable
	reg double_speed_bit; // eight samples per bit
	reg sync_mode; // use transfer clock pin
	reg parity_enable_bit; // parity checking on
	reg parity_type_bit; // one selects odd parity
	reg stop_bit_select; // stored only, receiver ignores it
	reg [2:0] char_size_code; // frame data width code
	reg [11:0] baud_div; // sample tick period minus one

	// pin synchronisers
	reg rxd_meta, rxd_sync;
	reg tclk_meta, tclk_sync, tclk_prev;

	// sample tick generator
	reg [11:0] div_cnt;
	reg tick;

	// receiver datapath
	reg [1:0] state;
	reg [4:0] samp; // sample number within a bit, from one
	reg [3:0] bit_idx; // data and parity bit index
	reg [1:0] votes; // first two centre samples
	reg last_line; // line level at previous tick
	reg [8:0] shift; // receive shift register
	reg par_rx; // received parity bit

	// completed frame held outside the fifo
	reg pend_valid;
	reg [8:0] pend_data;
	reg pend_ferr, pend_pe;
	reg ovr_pending; // frames lost since last transfer

	// two-entry receive fifo
	reg [8:0] fifo_data [0:1];
	reg [1:0] fifo_ferr, fifo_ovr, fifo_pe;
	reg rd_ptr;
	reg [1:0] count;

	// majority of three samples
	function maj3;
		input a, b, c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	// number of data bits for a size code
	function [3:0] frame_bits;
		input [2:0] code;
		begin
			case (code)
				3'h0: frame_bits = 4'h5;
				3'h1: frame_bits = 4'h6;
				3'h2: frame_bits = 4'h7;
				`CSZ_9BIT: frame_bits = 4'h9;
				default: frame_bits = 4'h8;
			endcase
		end
	endfunction

	// address is one of the mapped registers
	function addr_ok;
		input [ADDR_W-1:0] a;
		begin
			addr_ok = (a == `OFS_STATUS) || (a == `OFS_CONTROL) || (a == `OFS_FRAME_CFG) ||
				(a == `OFS_DATA) || (a == `OFS_BAUD_DIV);
		end
	endfunction

	// derived timing and frame shape
	wire [4:0] spb = double_speed_bit ? `SPB_DOUBLE : `SPB_NORMAL;
	wire [4:0] first = double_speed_bit ? `FIRST_DOUBLE : `FIRST_NORMAL;
	wire [4:0] last_centre = first + 5'h02;
	wire [3:0] nbits = frame_bits(char_size_code);
	wire [3:0] total = nbits + {3'h0, parity_enable_bit};
	wire tclk_rise = tclk_sync & ~tclk_prev;
	wire busy = (state != ST_IDLE);

	// bit decision event and value, async vote or sync edge
	wire bit_event = sync_mode ? (tclk_rise & busy) : (tick & busy & (samp == last_centre));
	wire bit_val = sync_mode ? rxd_sync : maj3(votes[0], votes[1], rxd_sync);
	wire start_seen = sync_mode ? (tclk_rise & ~busy & ~rxd_sync) : (tick & ~busy & last_line & ~rxd_sync);
	wire frame_done = (state == ST_STOP) & bit_event;

	// bus handshakes
	wire wr_fire = awready & awvalid & wvalid;
	wire rd_fire = arready & arvalid;
	wire head_valid = (count != 2'h0);
	wire pop = rd_fire & (araddr == `OFS_DATA) & head_valid;
	wire push = pend_valid & (count != 2'h2);
	wire wr_ptr = rd_ptr ^ count[0];

	// pin synchronisers, two flops each
	always @(posedge aclk) begin
		if (!aresetn) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			tclk_meta <= 1'b0;
			tclk_sync <= 1'b0;
			tclk_prev <= 1'b0;
		end else begin
			rxd_meta <= rxd_pin;
			rxd_sync <= rxd_meta;
			tclk_meta <= transfer_clock_pin;
			tclk_sync <= tclk_meta;
			tclk_prev <= tclk_sync;
		end
	end

	// sample tick at oversampling rate
	// oversample clock tick
	always @(posedge aclk) begin
		if (!aresetn || !rx_enable_bit) begin
			div_cnt <= 12'h000;
			tick <= 1'b0;
		end else if (div_cnt == baud_div) begin
			div_cnt <= 12'h000;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 12'h001;
			tick <= 1'b0;
		end
	end

	// receiver state machine
	// disable aborts reception
	always @(posedge aclk) begin
		if (!aresetn || !rx_enable_bit) begin
			state <= ST_IDLE;
			samp <= 5'h01;
			bit_idx <= 4'h0;
			votes <= 2'h0;
			last_line <= 1'b1;
			shift <= 9'h000;
			par_rx <= 1'b0;
		end else begin
			// line history for falling edge search
			if (tick)
				last_line <= rxd_sync;
			if (tick && busy) begin
				samp <= (samp == spb) ? 5'h01 : samp + 5'h01;
				if (samp == first)
					votes[0] <= rxd_sync;
				if (samp == first + 5'h01)
					votes[1] <= rxd_sync;
			end
			case (state)
				ST_IDLE: begin
					if (start_seen) begin
						shift <= 9'h000;
						bit_idx <= 4'h0;
						samp <= 5'h02;
						state <= sync_mode ? ST_BITS : ST_START;
					end
				end
				ST_START: begin
					if (bit_event)
						state <= bit_val ? ST_IDLE : ST_BITS;
				end
				ST_BITS: begin
					if (bit_event) begin
						if (bit_idx < nbits)
							shift[bit_idx] <= bit_val;
						else
							par_rx <= bit_val;
						bit_idx <= bit_idx + 4'h1;
						if (bit_idx == total - 4'h1)
							state <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (bit_event)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// hold register and receive fifo
	// disable flushes buffer
	always @(posedge aclk) begin
		if (!aresetn || !rx_enable_bit) begin
			pend_valid <= 1'b0;
			pend_data <= 9'h000;
			pend_ferr <= 1'b0;
			pend_pe <= 1'b0;
			ovr_pending <= 1'b0;
			fifo_data[0] <= 9'h000;
			fifo_data[1] <= 9'h000;
			fifo_ferr <= 2'h0;
			fifo_ovr <= 2'h0;
			fifo_pe <= 2'h0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				fifo_data[wr_ptr] <= pend_data;
				fifo_ferr[wr_ptr] <= pend_ferr;
				fifo_pe[wr_ptr] <= pend_pe;
				fifo_ovr[wr_ptr] <= ovr_pending;
				ovr_pending <= 1'b0;
				pend_valid <= 1'b0;
			end
			// new start while full and held
			if (start_seen && pend_valid && count == 2'h2) begin
				pend_valid <= 1'b0;
				ovr_pending <= 1'b1;
			end
			if (frame_done) begin
				pend_valid <= 1'b1;
				pend_data <= shift;
				pend_ferr <= ~bit_val;
				pend_pe <= parity_enable_bit & (par_rx != (^shift ^ parity_type_bit));
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			case ({push, pop})
				2'b10: count <= count + 2'h1;
				2'b01: count <= count - 2'h1;
				default: count <= count;
			endcase
		end
	end

	// axi write path and control registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			rx_enable_bit <= 1'b0;
			rx_complete_irq_enable <= 1'b0;
			double_speed_bit <= 1'b0;
			sync_mode <= 1'b0;
			parity_enable_bit <= 1'b0;
			parity_type_bit <= 1'b0;
			stop_bit_select <= 1'b0;
			char_size_code <= `CSZ_RESET;
			baud_div <= `BAUD_DIV_RESET;
		end else begin
			// take address and data together
			awready <= ~awready & awvalid & wvalid & ~bvalid;
			wready <= ~awready & awvalid & wvalid & ~bvalid;
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= addr_ok(awaddr) ? `RESP_OKAY : `RESP_SLVERR;
				if (wstrb[0]) begin
					case (awaddr)
						`OFS_STATUS: double_speed_bit <= wdata[`ST_DOUBLE];
						`OFS_CONTROL: begin
							rx_complete_irq_enable <= wdata[`CB_IRQEN];
							rx_enable_bit <= wdata[`CB_ENABLE];
							char_size_code[2] <= wdata[`CB_CSZ2];
						end
						`OFS_FRAME_CFG: begin
							sync_mode <= wdata[`FC_SYNC];
							parity_enable_bit <= wdata[`FC_PEN];
							parity_type_bit <= wdata[`FC_PODD];
							stop_bit_select <= wdata[`FC_STOP];
							char_size_code[1:0] <= wdata[`FC_CSZ1:`FC_CSZ0];
						end
						`OFS_BAUD_DIV: baud_div[7:0] <= wdata[7:0];
						default: baud_div <= baud_div;
					endcase
				end
				if (wstrb[1] && awaddr == `OFS_BAUD_DIV)
					baud_div[11:8] <= wdata[11:8];
			end
		end
	end

	// head entry fields, zero when empty
	// empty reads zero
	wire [8:0] head_data = head_valid ? fifo_data[rd_ptr] : 9'h000;
	wire head_ferr = head_valid & fifo_ferr[rd_ptr];
	wire head_ovr = head_valid & fifo_ovr[rd_ptr];
	wire head_pe = head_valid & fifo_pe[rd_ptr];

	// read data multiplexer
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h00000000;
		case (araddr)
			`OFS_STATUS: begin
				rd_mux[`ST_COMPLETE] = head_valid;
				rd_mux[`ST_FRAME_ERR] = head_ferr;
				rd_mux[`ST_OVERRUN] = head_ovr;
				rd_mux[`ST_PE] = head_pe;
				rd_mux[`ST_DOUBLE] = double_speed_bit;
			end
			`OFS_CONTROL: begin
				rd_mux[`CB_IRQEN] = rx_complete_irq_enable;
				rd_mux[`CB_ENABLE] = rx_enable_bit;
				rd_mux[`CB_CSZ2] = char_size_code[2];
				rd_mux[`CB_NINTH] = head_data[8];
			end
			`OFS_FRAME_CFG: begin
				rd_mux[`FC_SYNC] = sync_mode;
				rd_mux[`FC_PEN] = parity_enable_bit;
				rd_mux[`FC_PODD] = parity_type_bit;
				rd_mux[`FC_STOP] = stop_bit_select;
				rd_mux[`FC_CSZ1:`FC_CSZ0] = char_size_code[1:0];
			end
			`OFS_DATA: rd_mux[7:0] = head_data[7:0];
			`OFS_BAUD_DIV: rd_mux[11:0] = baud_div;
			default: rd_mux = 32'h00000000;
		endcase
	end

	// axi read path
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			arready <= ~arready & arvalid & ~rvalid;
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (rd_fire) begin
				rvalid <= 1'b1;
				rdata <= rd_mux;
				rresp <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	// pin override and receive complete request
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_pin_override <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			rx_pin_override <= rx_enable_bit;
			rx_irq <= rx_complete_irq_enable & head_valid;
		end
	end

endmodule // uart_serial_receiver

`default_nettype wire

// ===== pkg/uart_rx_regs.vh
// register offsets, field positions, reset values and sample counts of the serial receiver
`ifndef UART_RX_REGS_VH
`define UART_RX_REGS_VH

// register byte offsets
`define OFS_STATUS 5'h00
`define OFS_CONTROL 5'h04
`define OFS_FRAME_CFG 5'h08
`define OFS_DATA 5'h0C
`define OFS_BAUD_DIV 5'h10

// serial_status_a fields
`define ST_COMPLETE 7
`define ST_FRAME_ERR 4
`define ST_OVERRUN 3
`define ST_PE 2
`define ST_DOUBLE 1

// serial_control_b fields
`define CB_IRQEN 7
`define CB_ENABLE 4
`define CB_CSZ2 2
`define CB_NINTH 1

// serial_frame_config fields
`define FC_SYNC 6
`define FC_PEN 5
`define FC_PODD 4
`define FC_STOP 3
`define FC_CSZ1 2
`define FC_CSZ0 1

// reset values
`define BAUD_DIV_RESET 12'h035
`define CSZ_RESET 3'h3

// character size code for nine data bits
`define CSZ_9BIT 3'h7

// oversampling: samples per bit and first centre sample
`define SPB_NORMAL 5'h10
`define SPB_DOUBLE 5'h08
`define FIRST_NORMAL 5'h08
`define FIRST_DOUBLE 5'h04

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== tb/serial_partner.sv
// remote serial transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none
module serial_partner (
	// system clock for bit timing
	input wire logic clk,
	// serial line and transfer clock
	output logic line,
	output logic tclk
);
	// line idles high, transfer clock still between frames
	initial begin
		line = 1'b1;
		tclk = 1'b0;
	end
	// start bit, then n bits lsb first, then one idle bit
	task automatic frame(input logic [10:0] b, input int n, input int bt, input bit sy);
		for (int i = -1; i < n; i++) begin
			line <= (i < 0) ? 1'b0 : b[i];
			repeat (bt / 2) @(posedge clk);
			tclk <= sy;
			repeat (bt / 2) @(posedge clk);
			tclk <= 1'b0;
		end
		line <= 1'b1;
		repeat (bt) @(posedge clk);
	endtask
	// short low spike that is no start bit
	task automatic pulse(input int w);
		line <= 1'b0;
		repeat (w) @(posedge clk);
		line <= 1'b1;
		repeat (32) @(posedge clk);
	endtask
endmodule // serial_partner
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the serial receiver
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_regs.vh"
module testbench;
	// bus side
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	wire logic awready, wready, bvalid, arready, rvalid, rx_pin_override, rx_irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	// serial side
	wire logic line, tclk;
	// bookkeeping
	int n_errors = 0;
	int total_checks = 0;
	int bt = 16;
	bit sy = 0;
	logic [1:0] rs;
	logic [31:0] rv; // last read word
	int nr; // data reads while draining
	uart_serial_receiver i_uart_serial_receiver (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rxd_pin(line), .transfer_clock_pin(tclk),
		.rx_pin_override(rx_pin_override), .rx_irq(rx_irq));
	serial_partner i_serial_partner (.clk(aclk), .line(line), .tclk(tclk));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one bus write, response code kept in rs
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bit ad, dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each half released at the edge that takes it
		while (!(ad && dd)) begin
			@(posedge aclk);
			if (!ad && awready === 1'b1) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!dd && wready === 1'b1) begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		rs = bresp;
		bready <= 1'b0;
	endtask
	// one bus read compared with an expected word
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rs = rresp;
		rv = rdata;
		rready <= 1'b0;
		chk(rdata, e);
	endtask
	// frame of nd data bits, optional parity bit, then stop
	task automatic snd(input logic [8:0] d, input int nd, input int np, input logic pb, input logic sb);
		logic [10:0] b;
		b = {2'b00, d} & ((11'h1 << nd) - 11'h1);
		b[nd] = np ? pb : sb;
		b[nd + 1] = sb;
		i_serial_partner.frame(b, nd + np + 1, bt, sy);
	endtask
	// verdict and end of run
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// free-running clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// hang guard
	initial begin
		repeat (40000) @(posedge aclk);
		n_errors++;
		complete_run;
	end
	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 42'h0;
		wstrb = 4'hF;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(`OFS_STATUS, 32'h0);
		rd_chk(`OFS_FRAME_CFG, 32'h6);
		wr(5'h14, 32'hFFFFFFFF);
		chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
		rd_chk(`OFS_BAUD_DIV, 32'h35);
		rd_chk(5'h14, 32'h0);
		chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
		wr(`OFS_BAUD_DIV, 32'h0);
		chk({30'h0, rs}, {30'h0, `RESP_OKAY});
		wr(`OFS_CONTROL, 32'h10);
		repeat (2) @(posedge aclk);
		chk(rx_pin_override, 1'b1);
		// sizes five to eight bits
		for (int c = 0; c < 4; c++) begin
			wr(`OFS_FRAME_CFG, c << 1);
			snd(9'h0B5, c + 5, 0, 1'b0, 1'b1);
			rd_chk(`OFS_STATUS, 32'h80);
			rd_chk(`OFS_DATA, 32'hB5 & ((32'h1 << (c + 5)) - 1));
			rd_chk(`OFS_STATUS, 32'h0);
		end
		// even then odd parity, good frame queued ahead of a bad one
		for (int o = 0; o < 2; o++) begin
			wr(`OFS_FRAME_CFG, 32'h26 | (o << 4));
			snd(9'h03, 8, 1, o[0], 1'b1);
			snd(9'h03, 8, 1, !o[0], 1'b0);
			rd_chk(`OFS_STATUS, 32'h80);
			rd_chk(`OFS_DATA, 32'h03);
			rd_chk(`OFS_STATUS, 32'h94);
			rd_chk(`OFS_DATA, 32'h03);
		end
		// four frames unread: third one lost
		wr(`OFS_FRAME_CFG, 32'h6);
		for (int k = 1; k < 5; k++) snd(9'(k), 8, 0, 1'b0, 1'b1);
		rd_chk(`OFS_DATA, 32'h1);
		rd_chk(`OFS_STATUS, 32'h80);
		rd_chk(`OFS_DATA, 32'h2);
		rd_chk(`OFS_STATUS, 32'h88);
		rd_chk(`OFS_DATA, 32'h4);
		// drain by reading data until the complete flag clears
		snd(9'h66, 8, 0, 1'b0, 1'b1);
		snd(9'h77, 8, 0, 1'b0, 1'b1);
		nr = 0;
		rd_chk(`OFS_STATUS, 32'h80);
		while (rv[`ST_COMPLETE] === 1'b1 && nr < 4) begin
			rd_chk(`OFS_DATA, (nr == 0) ? 32'h66 : 32'h77);
			nr++;
			rd_chk(`OFS_STATUS, (nr < 2) ? 32'h80 : 32'h0);
		end
		chk(nr, 2);
		// nine-bit characters
		wr(`OFS_CONTROL, 32'h14);
		snd(9'h1A5, 9, 0, 1'b0, 1'b1);
		rd_chk(`OFS_CONTROL, 32'h16);
		rd_chk(`OFS_DATA, 32'hA5);
		rd_chk(`OFS_CONTROL, 32'h14);
		// request level follows the buffer
		wr(`OFS_CONTROL, 32'h90);
		snd(9'h5A, 8, 0, 1'b0, 1'b1);
		chk(rx_irq, 1'b1);
		rd_chk(`OFS_DATA, 32'h5A);
		repeat (2) @(posedge aclk);
		chk(rx_irq, 1'b0);
		// disable in mid-frame with one entry stored
		snd(9'h11, 8, 0, 1'b0, 1'b1);
		fork
			snd(9'h22, 8, 0, 1'b0, 1'b1);
			begin
				repeat (60) @(posedge aclk);
				wr(`OFS_CONTROL, 32'h80);
			end
		join
		chk({rx_irq, rx_pin_override}, 2'b00);
		wr(`OFS_CONTROL, 32'h10);
		rd_chk(`OFS_STATUS, 32'h0);
		// double speed, error positions written as zero
		wr(`OFS_STATUS, 32'h2);
		bt = 8;
		snd(9'h3C, 8, 0, 1'b0, 1'b1);
		rd_chk(`OFS_STATUS, 32'h82);
		rd_chk(`OFS_DATA, 32'h3C);
		// spike rejected at normal speed
		wr(`OFS_STATUS, 32'h0);
		bt = 16;
		i_serial_partner.pulse(5);
		// long enough for a falsely started frame to complete
		repeat (160) @(posedge aclk);
		rd_chk(`OFS_STATUS, 32'h0);
		// synchronous mode on the transfer clock
		wr(`OFS_FRAME_CFG, 32'h46);
		sy = 1'b1;
		snd(9'hC3, 8, 0, 1'b0, 1'b1);
		rd_chk(`OFS_DATA, 32'hC3);
		complete_run;
	end
endmodule // testbench
`default_nettype wire

// ===== tb/uart_rx_properties.sv
// port assertions for the serial receiver
`timescale 1ns/100ps
`default_nettype none
module uart_rx_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// read side
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// receiver pins
	input wire logic rx_pin_override,
	input wire logic rx_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// both halves of a write are taken together
	chk_write_pair: assert property (awready |-> wready && awvalid && wvalid)
		else $error("write halves taken apart");
	// a complete write request is taken within two cycles
	chk_write_prompt: assert property (awvalid && wvalid && !bvalid && !awready |-> ##[1:2] awready)
		else $error("write request not taken");
	// response follows the taking edge
	chk_write_answer: assert property (awready |=> bvalid)
		else $error("write response missing");
	// no new write while a response waits
	chk_write_refused: assert property (bvalid |-> !awready)
		else $error("write taken during response");
	// response held until accepted
	chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	// read answer after the taking edge
	chk_read_answer: assert property (arready && arvalid |=> rvalid)
		else $error("read data missing");
	// read data held until accepted
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	// refused reads carry no data
	chk_err_no_data: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
		else $error("error read with data");
	// request only while the receiver owned the pin
	chk_irq_needs_rx: assert property (rx_irq |-> $past(rx_pin_override))
		else $error("request while receiver off");
	// no new read while read data waits
	chk_read_refused: assert property (rvalid |-> !arready)
		else $error("read taken during data");
	// request drops once the receiver is off
	chk_irq_off: assert property (!rx_pin_override |=> !rx_irq)
		else $error("request after disable");
endmodule // uart_rx_checker
bind uart_serial_receiver uart_rx_checker i_uart_rx_checker (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_pin_override(rx_pin_override),
	.rx_irq(rx_irq));
`default_nettype wire
